/* dacd_checker.sv */
`include "dacd_defs.svh"

module dacd_checker
	import dacd_pkg::*;
(
	input  wire logic             clk_sys_in,
	input  wire logic             sys_rst_in,
	input  wire dacd_apb_req_t    apb_req_in,
	input  wire dacd_apb_rsp_t    apb_rsp_out,
	input  wire dacd_chan_write_t chan_write_out,
	input  wire logic             force_output_to_ground_out,
	input  wire logic             busy_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	logic acc;
	logic dwr;
	logic vld;
	assign acc = apb_req_in.psel && apb_req_in.penable;
	assign dwr = acc && apb_req_in.pwrite && apb_req_in.paddr == `DACD_OFF_CMD_DATA;
	assign vld = chan_write_out.valid;
	serr_phase_a: assert property (apb_rsp_out.pslverr |-> acc)
		else $error("slave error outside access phase");
	type_legal_a: assert property (vld |-> chan_write_out.reg_type != `DACD_TYPE_SPECIAL)
		else $error("channel write with special type");
	chan_range_a: assert property (vld |-> chan_write_out.channel <= `DACD_LAST_CH)
		else $error("channel number out of range");
	gnd_init_a: assert property ($fell(sys_rst_in) |-> force_output_to_ground_out && busy_out)
		else $error("outputs not grounded after reset");
	quiet_init_a: assert property ($fell(sys_rst_in) |-> !vld [*8])
		else $error("channel write during init sweep");
	data_wait_a: assert property (dwr && busy_out |-> !apb_rsp_out.pready)
		else $error("data write accepted while busy");
	launch_busy_a: assert property (dwr && apb_rsp_out.pready && !busy_out |=> busy_out)
		else $error("data write did not start sequencer");
	pulse_busy_a: assert property (vld |-> $past(busy_out))
		else $error("channel write without operation");
	scan_order_a: assert property (vld ##1 vld |->
		chan_write_out.channel == $past(chan_write_out.channel) + 6'h1)
		else $error("channel scan out of order");
	cover property (dwr && busy_out);
	cover property (vld && chan_write_out.reg_type == `DACD_TYPE_OFFSET);
	cover property ($fell(force_output_to_ground_out));
endmodule

bind dacd_decoder dacd_checker chk_u (
	.clk_sys_in                 (clk_sys_in),
	.sys_rst_in                 (sys_rst_in),
	.apb_req_in                 (apb_req_in),
	.apb_rsp_out                (apb_rsp_out),
	.chan_write_out             (chan_write_out),
	.force_output_to_ground_out (force_output_to_ground_out),
	.busy_out                   (busy_out)
);

/* dacd_decoder.sv */
// Register access over APB and the register offsets were left to the implementer.
`include "dacd_defs.svh"

module dacd_decoder
	import dacd_pkg::*;
(
	input  wire logic             clk_sys_in,
	input  wire logic             sys_rst_in,
	input  wire dacd_apb_req_t    apb_req_in,
	output dacd_apb_rsp_t         apb_rsp_out,
	output dacd_chan_write_t      chan_write_out,
	output logic                  force_output_to_ground_out,
	output logic                  busy_out
);

	dacd_state_t             state_reg;
	logic [7:0]              channel_address_bus_reg;
	logic                    register_type_select_hi_reg;
	logic                    register_type_select_lo_reg;
	logic [`DACD_WORD_W-1:0] write_word_bus_reg;
	logic [5:0]              ch_reg;
	logic [1:0]              init_type_reg;
	logic                    ground_reg;
	logic                    ctrl_ground_reg;
	logic [9:0]              rb_sel_reg;
	logic                    rb_issued_reg;
	logic                    rb_done_reg;
	logic [31:0]             prdata_reg;
	logic                    pslverr_reg;
	logic [`DACD_CHANNELS-1:0] sel_vec;
	logic [1:0]              type_sel;
	logic                    acc;
	logic                    setup;
	logic                    is_launch;
	logic                    launch;
	logic                    is_rb;
	logic                    mem_we;
	logic [`DACD_MEM_AW-1:0] mem_addr;
	logic [`DACD_WORD_W-1:0] mem_wdata;
	logic [`DACD_WORD_W-1:0] mem_rdata;
	logic [`DACD_WORD_W-1:0] adjusted;
	logic                    last_ch;

	// Returns true when the offset is one of the mapped registers.
	function automatic logic dacd_mapped(input logic [7:0] off);
		return (off == `DACD_OFF_CMD_ADDR) || (off == `DACD_OFF_CMD_DATA) ||
			(off == `DACD_OFF_STATUS) || (off == `DACD_OFF_CTRL) ||
			(off == `DACD_OFF_RB_SEL) || (off == `DACD_OFF_RB_DATA);
	endfunction

	// Default content of one register type.
	function automatic logic [`DACD_WORD_W-1:0] dacd_default(input logic [1:0] t);
		logic [`DACD_WORD_W-1:0] v;
		v = `DACD_RST_CODE;
		if (t == `DACD_TYPE_OFFSET) begin
			v = `DACD_RST_OFFSET;
		end else if (t == `DACD_TYPE_GAIN) begin
			v = `DACD_RST_GAIN;
		end
		return v;
	endfunction

	assign type_sel  = {register_type_select_hi_reg, register_type_select_lo_reg};
	assign setup     = apb_req_in.psel && !apb_req_in.penable;
	assign acc       = apb_req_in.psel && apb_req_in.penable;
	assign is_launch = apb_req_in.pwrite && (apb_req_in.paddr == `DACD_OFF_CMD_DATA);
	assign is_rb     = !apb_req_in.pwrite && (apb_req_in.paddr == `DACD_OFF_RB_DATA);
	assign launch    = acc && is_launch && (state_reg == DACD_IDLE);
	assign last_ch   = (ch_reg == `DACD_LAST_CH);

	// Channel c sits in group c/10 at index c%10.
	generate
		for (genvar c = 0; c < `DACD_CHANNELS; c++) begin : g_sel
			localparam int GRP = c / `DACD_PER_GROUP;
			localparam int IDX = c % `DACD_PER_GROUP;
			always_comb begin
				if (channel_address_bus_reg[7:4] == 4'h0) begin
					sel_vec[c] = 1'b1;
				end else begin
					sel_vec[c] = channel_address_bus_reg[4 + GRP] &&
						(channel_address_bus_reg[3:0] == 4'(IDX));
				end
			end
		end
	endgenerate

	// increment or decrement with clamping at both ends.
	always_comb begin
		logic [14:0] sum;
		logic [14:0] step;
		sum  = 15'h0000;
		step = {8'h00, write_word_bus_reg[`DACD_STEP_MSB:0]};
		if (write_word_bus_reg[`DACD_DIR_BIT]) begin
			sum = {1'b0, mem_rdata} + step;
			if (sum > `DACD_FULL_SCALE) begin
				sum = `DACD_FULL_SCALE;
			end
		end else if ({1'b0, mem_rdata} < step) begin
			sum = 15'h0000;
		end else begin
			sum = {1'b0, mem_rdata} - step;
		end
		adjusted = sum[13:0];
	end

	// The sequencer owns the memory port; readback only borrows it when idle.
	always_comb begin
		mem_we    = 1'b0;
		mem_wdata = write_word_bus_reg;
		mem_addr  = {rb_sel_reg[`DACD_RB_TYPE_MSB:`DACD_RB_TYPE_LSB],
			rb_sel_reg[`DACD_RB_CH_MSB:0]};
		unique case (state_reg)
			DACD_IDLE: begin
			end
			DACD_INIT: begin
				mem_we    = 1'b1;
				mem_wdata = dacd_default(init_type_reg);
				mem_addr  = {init_type_reg, ch_reg};
			end
			DACD_SCAN: begin
				mem_addr = {type_sel, ch_reg};
				mem_we   = sel_vec[ch_reg] && (type_sel != `DACD_TYPE_SPECIAL);
				if (type_sel == `DACD_TYPE_SPECIAL) begin
					mem_addr = {`DACD_TYPE_CODE, ch_reg};
				end
			end
			DACD_MODIFY: begin
				mem_we    = 1'b1;
				mem_wdata = adjusted;
				mem_addr  = {`DACD_TYPE_CODE, ch_reg};
			end
		endcase
	end

	dacd_mem u_mem (
		.clk_sys_in (clk_sys_in),
		.wr_en_in   (mem_we),
		.addr_in    (mem_addr),
		.wdata_in   (mem_wdata),
		.rdata_out  (mem_rdata)
	);

	// Sequencer: init sweep after reset or soft reset, then one channel per step.
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			state_reg     <= DACD_INIT;
			ch_reg        <= 6'h00;
			init_type_reg <= `DACD_TYPE_GAIN;
		end else begin
			unique case (state_reg)
				DACD_IDLE: begin
					ch_reg <= 6'h00;
					if (launch) begin
						if (type_sel == `DACD_TYPE_SPECIAL &&
							apb_req_in.pwdata[13:0] == `DACD_SOFT_RESET_WORD) begin
							state_reg     <= DACD_INIT;
							init_type_reg <= `DACD_TYPE_GAIN;
						end else begin
							state_reg <= DACD_SCAN;
						end
					end
				end
				DACD_INIT: begin
					ch_reg <= last_ch ? 6'h00 : ch_reg + 6'h01;
					if (last_ch) begin
						init_type_reg <= init_type_reg + 2'h1;
						if (init_type_reg == `DACD_TYPE_CODE) begin
							state_reg <= DACD_IDLE;
						end
					end
				end
				DACD_SCAN: begin
					if (type_sel == `DACD_TYPE_SPECIAL && sel_vec[ch_reg]) begin
						state_reg <= DACD_MODIFY;
					end else if (last_ch) begin
						state_reg <= DACD_IDLE;
					end else begin
						ch_reg <= ch_reg + 6'h01;
					end
				end
				DACD_MODIFY: begin
					if (last_ch) begin
						state_reg <= DACD_IDLE;
					end else begin
						ch_reg    <= ch_reg + 6'h01;
						state_reg <= DACD_SCAN;
					end
				end
			endcase
		end
	end

	// Report every register update except the init sweep writes to the converter core.
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			chan_write_out <= '0;
		end else begin
			chan_write_out.valid    <= mem_we && (state_reg != DACD_INIT);
			chan_write_out.reg_type <= mem_addr[7:6];
			chan_write_out.channel  <= mem_addr[5:0];
			chan_write_out.data     <= mem_wdata;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ground_reg <= 1'b1;
		end else if (state_reg == DACD_INIT) begin
			ground_reg <= 1'b1;
		end else if (mem_we && mem_addr[7:6] == `DACD_TYPE_CODE) begin
			ground_reg <= 1'b0;
		end
	end

	assign force_output_to_ground_out = ground_reg || ctrl_ground_reg;
	assign busy_out                   = (state_reg != DACD_IDLE);

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			channel_address_bus_reg     <= 8'h00;
			register_type_select_hi_reg <= 1'b1;
			register_type_select_lo_reg <= 1'b1;
			write_word_bus_reg          <= 14'h0000;
			ctrl_ground_reg             <= 1'b0;
			rb_sel_reg                  <= 10'h000;
		end else if (acc && apb_req_in.pwrite && apb_rsp_out.pready) begin
			unique case (apb_req_in.paddr)
				`DACD_OFF_CMD_ADDR: begin
					if (state_reg == DACD_IDLE) begin
						channel_address_bus_reg <=
							apb_req_in.pwdata[`DACD_ADDR_MSB:`DACD_ADDR_LSB];
						register_type_select_hi_reg <= apb_req_in.pwdata[`DACD_TSEL_HI_BIT];
						register_type_select_lo_reg <= apb_req_in.pwdata[`DACD_TSEL_LO_BIT];
					end
				end
				`DACD_OFF_CMD_DATA: begin
					write_word_bus_reg <= apb_req_in.pwdata[13:0];
				end
				`DACD_OFF_CTRL: begin
					ctrl_ground_reg <= apb_req_in.pwdata[0];
				end
				`DACD_OFF_RB_SEL: begin
					rb_sel_reg <= apb_req_in.pwdata[9:0];
				end
				default: begin
				end
			endcase
		end
	end

	// Readback waits for an idle sequencer, then spends one cycle in the memory.
	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			rb_issued_reg <= 1'b0;
			rb_done_reg   <= 1'b0;
		end else begin
			rb_issued_reg <= acc && is_rb && !rb_issued_reg && !rb_done_reg &&
				(state_reg == DACD_IDLE);
			rb_done_reg   <= rb_issued_reg;
		end
	end

	always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (rb_issued_reg) begin
			prdata_reg <= {18'h00000, mem_rdata};
		end else if (setup) begin
			pslverr_reg <= !dacd_mapped(apb_req_in.paddr);
			prdata_reg  <= 32'h0000_0000;
			unique case (apb_req_in.paddr)
				`DACD_OFF_CMD_ADDR: begin
					prdata_reg[9:0] <= {type_sel, channel_address_bus_reg};
				end
				`DACD_OFF_CMD_DATA: begin
					prdata_reg[13:0] <= write_word_bus_reg;
				end
				`DACD_OFF_STATUS: begin
					prdata_reg[`DACD_ST_BUSY_BIT]   <= busy_out;
					prdata_reg[`DACD_ST_GROUND_BIT] <= force_output_to_ground_out;
					prdata_reg[`DACD_ST_INIT_BIT]   <= (state_reg == DACD_INIT);
				end
				`DACD_OFF_CTRL: begin
					prdata_reg[0] <= ctrl_ground_reg;
				end
				`DACD_OFF_RB_SEL: begin
					prdata_reg[9:0] <= rb_sel_reg;
				end
				default: begin
				end
			endcase
		end
	end

	// A command word stalls the bus while a previous one is still running.
	always_comb begin
		apb_rsp_out.pready  = 1'b1;
		apb_rsp_out.pslverr = acc && pslverr_reg;
		apb_rsp_out.prdata  = prdata_reg;
		if (acc && is_launch) begin
			apb_rsp_out.pready = (state_reg == DACD_IDLE);
		end else if (acc && is_rb) begin
			apb_rsp_out.pready = rb_done_reg;
		end
	end

endmodule

/* dacd_defs.svh */
`ifndef DACD_DEFS_SVH
`define DACD_DEFS_SVH

// Register byte offsets on the APB port.
`define DACD_OFF_CMD_ADDR    8'h00
`define DACD_OFF_CMD_DATA    8'h04
`define DACD_OFF_STATUS      8'h08
`define DACD_OFF_CTRL        8'h0C
`define DACD_OFF_RB_SEL      8'h10
`define DACD_OFF_RB_DATA     8'h14

// Field layout of the command address register.
`define DACD_ADDR_LSB        0
`define DACD_ADDR_MSB        7
`define DACD_TSEL_LO_BIT     8
`define DACD_TSEL_HI_BIT     9

// Field layout of the status register.
`define DACD_ST_BUSY_BIT     0
`define DACD_ST_GROUND_BIT   1
`define DACD_ST_INIT_BIT     2

// Field layout of the readback select register.
`define DACD_RB_CH_MSB       5
`define DACD_RB_TYPE_LSB     8
`define DACD_RB_TYPE_MSB     9

// Field layout of an increment or decrement command word.
`define DACD_STEP_MSB        6
`define DACD_DIR_BIT         8

// Register type select codes.
`define DACD_TYPE_SPECIAL    2'h0
`define DACD_TYPE_GAIN       2'h1
`define DACD_TYPE_OFFSET     2'h2
`define DACD_TYPE_CODE       2'h3

// Geometry.
`define DACD_CHANNELS        40
`define DACD_GROUPS          4
`define DACD_PER_GROUP       10
`define DACD_LAST_CH         6'h27
`define DACD_WORD_W          14
`define DACD_MEM_AW          8
`define DACD_MEM_DEPTH       256

// Reset values, soft reset command word and full-scale clamp limit.
`define DACD_RST_CODE        14'h0000
`define DACD_RST_OFFSET      14'h2000
`define DACD_RST_GAIN        14'h3FFF
`define DACD_SOFT_RESET_WORD 14'h3FFF
`define DACD_FULL_SCALE      15'h3FFF

`endif

/* dacd_host_model.sv */
module dacd_host_model
	import dacd_pkg::*;
(
	input  wire logic          clk_sys_in,
	input  wire dacd_apb_rsp_t rsp_in,
	output dacd_apb_req_t      req_out = '0
);
	timeunit 1ns;
	timeprecision 1ns;
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		@(posedge clk_sys_in);
		req_out <= '{1'b1, 1'b0, wr, a, d};
		@(posedge clk_sys_in);
		req_out.penable <= 1'b1;
		do @(posedge clk_sys_in); while (rsp_in.pready !== 1'b1);
		q = rsp_in.prdata;
		err = rsp_in.pslverr;
		// Released lines show inverted values so a stale match cannot pass.
		req_out <= '{1'b0, 1'b0, ~wr, ~a, ~d};
	endtask
endmodule

/* dacd_mem.sv */
`include "dacd_defs.svh"

module dacd_mem
	import dacd_pkg::*;
(
	input  wire logic                     clk_sys_in,
	input  wire logic                     wr_en_in,
	input  wire logic [`DACD_MEM_AW-1:0]  addr_in,
	input  wire logic [`DACD_WORD_W-1:0]  wdata_in,
	output logic      [`DACD_WORD_W-1:0]  rdata_out
);

	logic [`DACD_WORD_W-1:0] store_reg [`DACD_MEM_DEPTH];

	// No reset here: the init sweep after reset loads the gain, offset and code entries of channels 0 to 39.
	always_ff @(posedge clk_sys_in) begin
		if (wr_en_in) begin
			store_reg[addr_in] <= wdata_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		rdata_out <= store_reg[addr_in];
	end

endmodule

/* dacd_pkg.sv */
package dacd_pkg;

	typedef enum logic [1:0] {
		DACD_IDLE,
		DACD_INIT,
		DACD_SCAN,
		DACD_MODIFY
	} dacd_state_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} dacd_apb_req_t;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} dacd_apb_rsp_t;

	typedef struct packed {
		logic        valid;
		logic [1:0]  reg_type;
		logic [5:0]  channel;
		logic [13:0] data;
	} dacd_chan_write_t;

endpackage

/* tb.sv */
module tb;
	import dacd_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [39:0] all_ch = {40{1'b1}};
	logic             clk_sys_in = 1'b0;
	logic             sys_rst_in = 1'b1;
	dacd_apb_req_t    req;
	dacd_apb_rsp_t    rsp;
	dacd_chan_write_t cw;
	logic             gnd;
	logic             busy;
	logic [39:0]      seen;
	logic [1:0]       exp_type;
	logic [13:0]      exp_data;
	logic [31:0]      q;
	logic [31:0]      r;
	logic             e;
	logic [7:0]       a;
	logic [1:0]       t;
	logic [7:0]       ctab [4] = '{8'hF9, 8'h1A, 8'h35, 8'hA0};
	int               err_count = 0;
	int               checked = 0;
	int               seed = 32'h6162BB99;

	always #25 clk_sys_in = ~clk_sys_in;

	dacd_decoder dut_u (
		.clk_sys_in                 (clk_sys_in),
		.sys_rst_in                 (sys_rst_in),
		.apb_req_in                 (req),
		.apb_rsp_out                (rsp),
		.chan_write_out             (cw),
		.force_output_to_ground_out (gnd),
		.busy_out                   (busy)
	);

	dacd_host_model host_u (
		.clk_sys_in (clk_sys_in),
		.rsp_in     (rsp),
		.req_out    (req)
	);

	task automatic chk(input string n, input logic [39:0] s, input logic [39:0] x);
		checked++;
		if (s !== x) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", n, x, s);
		end
	endtask

	function automatic logic [39:0] sel_mask(input logic [7:0] ad);
		logic [39:0] m;
		m = '0;
		if (ad[7:4] == 4'h0)
			m = all_ch;
		else if (ad[3:0] <= 4'h9)
			for (int g = 0; g < 4; g++)
				if (ad[4+g])
					m[g*10+ad[3:0]] = 1'b1;
		return m;
	endfunction

	always @(posedge clk_sys_in) begin
		if (cw.valid === 1'b1) begin
			seen[cw.channel] = 1'b1;
			chk("chan type", 40'(cw.reg_type), 40'(exp_type));
			chk("chan data", 40'(cw.data), 40'(exp_data));
		end
	end

	task automatic go(input logic [13:0] d, input logic [1:0] xt, input logic [13:0] xd,
		input logic [39:0] xm);
		int n;
		logic [5:0] ch;
		n = 0;
		ch = 6'h0;
		exp_type = xt;
		exp_data = xd;
		seen = '0;
		host_u.xfer(1'b1, 8'h04, {18'h0, d}, q, e);
		@(posedge clk_sys_in);
		while (busy !== 1'b0 && n < 400) begin
			@(posedge clk_sys_in);
			n++;
		end
		// A sequencer that never returns to idle is a hang, not a slow test.
		if (n >= 400) begin
			err_count++;
			tally_and_finish();
		end
		// The last channel pulse may trail the end of busy.
		repeat (2) @(posedge clk_sys_in);
		chk("selected channels", seen, xm);
		for (int c = 39; c >= 0; c--)
			if (xm[c])
				ch = 6'(c);
		if (xm != '0) begin
			host_u.xfer(1'b1, 8'h10, {22'h0, xt, 2'h0, ch}, q, e);
			host_u.xfer(1'b0, 8'h14, 32'h0, q, e);
			chk("readback", 40'(q[13:0]), 40'(xd));
		end
		$display("test op done");
	endtask

	task automatic op(input logic [7:0] ad, input logic [1:0] ty, input logic [13:0] d,
		input logic [1:0] xt, input logic [13:0] xd, input logic [39:0] xm);
		host_u.xfer(1'b1, 8'h00, {22'h0, ty, ad}, q, e);
		go(d, xt, xd, xm);
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		#1000000;
		err_count++;
		tally_and_finish();
	end

	initial begin
		repeat (5) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_sys_in);
		chk("ground", 40'(gnd), 40'h1);
		host_u.xfer(1'b0, 8'h08, 32'h0, q, e);
		chk("status", 40'(q[2:0]), 40'h7);
		// Address write lands during the init sweep and must be dropped.
		host_u.xfer(1'b1, 8'h00, {22'h0, 2'h1, 8'h0F}, q, e);
		host_u.xfer(1'b0, 8'h00, 32'h0, q, e);
		chk("cmd addr", 40'(q), 40'h300);
		go(14'h1234, 2'h3, 14'h1234, all_ch);
		chk("ground", 40'(gnd), 40'h0);
		op(8'h00, 2'h0, 14'h3FFF, 2'h3, 14'h0, '0);
		chk("ground", 40'(gnd), 40'h1);
		op(8'h0F, 2'h1, 14'h2AAA, 2'h1, 14'h2AAA, all_ch);
		chk("ground", 40'(gnd), 40'h1);
		op(8'h00, 2'h3, 14'h0030, 2'h3, 14'h0030, all_ch);
		chk("ground", 40'(gnd), 40'h0);
		for (int i = 0; i < 16; i++) begin
			r = $random(seed);
			a = (i < 4) ? ctab[i] : r[7:0];
			t = (r[9:8] == 2'h0) ? 2'h3 : r[9:8];
			op(a, t, r[29:16], t, r[29:16], sel_mask(a));
		end
		op(8'h00, 2'h3, 14'h0030, 2'h3, 14'h0030, all_ch);
		op(8'h00, 2'h0, 14'h0105, 2'h3, 14'h0035, all_ch);
		op(8'h00, 2'h0, 14'h007F, 2'h3, 14'h0, all_ch);
		op(8'h35, 2'h0, 14'h0107, 2'h3, 14'h0007, sel_mask(8'h35));
		host_u.xfer(1'b1, 8'h0C, 32'h1, q, e);
		@(posedge clk_sys_in);
		chk("ctrl ground", 40'(gnd), 40'h1);
		host_u.xfer(1'b0, 8'h0C, 32'h0, q, e);
		chk("ctrl readback", 40'(q), 40'h1);
		host_u.xfer(1'b1, 8'h0C, 32'h0, q, e);
		@(posedge clk_sys_in);
		chk("ctrl ground", 40'(gnd), 40'h0);
		$display("test ctrl done");
		host_u.xfer(1'b0, 8'h18, 32'h0, q, e);
		chk("unmapped", {7'h0, e, q}, 40'h100000000);
		$display("test unmapped done");
		tally_and_finish();
	end
endmodule
